// *** logic/pfr_fault_unit.sv ***
// protection fault detection and reporting unit
`timescale 1ns/1ps
module pfr_fault_unit
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pipeline fault conditions
  input wire logic check_valid,
  input wire logic [63:0] instr_ptr,
  input wire logic paging_enable_req,
  input wire logic not_write_through_req,
  input wire logic cache_disable_req,
  input wire logic [31:0] ctrl_write_data,
  input wire logic ctrl_write,
  input wire pfr_pkg::pfr_stack_t stack_in,
  input wire pfr_pkg::pfr_gp_t gp_in,
  input wire pfr_pkg::pfr_pf_t pf_in,
  input wire pfr_pkg::pfr_x87_t x87_in,
  // dispatch side
  output pfr_pkg::pfr_event_t fault_event
);
  logic [31:0] ctrl;
  logic [63:0] fault_address_register;
  logic [63:0] x87_last_ip;
  logic [31:0] last_err;
  logic [7:0] last_vec;
  pfr_pkg::pfr_event_t next_event;
  logic stk_hit;
  logic gp_sel_hit;
  logic gp_zero_hit;
  logic pf_hit;
  logic x87_hit;
  logic [5:0] x87_unmasked;
  logic long_mode;
  logic apb_wr;
  logic apb_rd;

  function automatic logic [31:0] sel_index(input logic [15:0] sel);
    sel_index = {16'h0000, sel[15:3], 3'b000};
  endfunction

  assign long_mode = ctrl[pfr_pkg::CTRL_LONG];
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !penable && !pwrite;

  // condition decode
  always_comb
  begin
    stk_hit = stack_in.noncanon_stack || stack_in.ss_not_present || stack_in.stack_limit;
    gp_sel_hit = gp_in.null_sel_load || gp_in.gate_null_sel || gp_in.sys_desc_in_local
      || (gp_in.busy_task && !gp_in.is_iret);
    gp_sel_hit = gp_sel_hit || (long_mode && (gp_in.ext_type_nonzero || gp_in.noncanon_base_off
      || gp_in.gate_not_64 || gp_in.gate_16 || gp_in.task_transfer));
    gp_zero_hit = (gp_in.instr_len > 5'(pfr_pkg::MAX_INSTR_BYTES))
      || (gp_in.priv_instr && gp_in.current_privilege_level != 2'b00)
      || (ctrl_write && |(ctrl_write_data & pfr_pkg::CTRL_MBZ))
      || (paging_enable_req && !ctrl[pfr_pkg::CTRL_PE])
      || (not_write_through_req && !cache_disable_req)
      || gp_in.seg_limit || gp_in.null_seg_access || gp_in.ro_seg_write
      || gp_in.sse_unaligned || gp_in.code_limit
      || gp_in.msr_ro || gp_in.msr_noncanon || gp_in.msr_bad_type;
    pf_hit = pf_in.not_present || pf_in.nx_fetch || pf_in.prot_fail
      || (pf_in.rsvd_bit && (ctrl[pfr_pkg::CTRL_PSE] || ctrl[pfr_pkg::CTRL_PAE]));
    x87_unmasked = x87_in.status[5:0] & ~x87_in.mask;
    x87_hit = ctrl[pfr_pkg::CTRL_NE] && |x87_unmasked && x87_in.wait_exec;
  end

  // one event per cycle, stack first, then protection, page, x87
  always_comb
  begin
    next_event = '0;
    next_event.saved_ip = instr_ptr;
    if (check_valid && stk_hit)
    begin
      next_event.valid = 1'b1;
      next_event.vector = pfr_pkg::VEC_STACK;
      next_event.err_valid = 1'b1;
      next_event.err_code = stack_in.ss_not_present ? sel_index(stack_in.ss_selector)
        : pfr_pkg::ERR_ZERO;
    end
    else if (check_valid && (gp_sel_hit || gp_zero_hit))
    begin
      next_event.valid = 1'b1;
      next_event.vector = pfr_pkg::VEC_GP;
      next_event.err_valid = 1'b1;
      next_event.err_code = gp_sel_hit ? sel_index(gp_in.selector) : pfr_pkg::ERR_ZERO;
    end
    else if (check_valid && pf_hit)
    begin
      next_event.valid = 1'b1;
      next_event.vector = pfr_pkg::VEC_PF;
      next_event.err_valid = 1'b1;
      next_event.err_code = pf_in.pf_err;
    end
    else if (check_valid && x87_hit)
    begin
      next_event.valid = 1'b1;
      next_event.vector = pfr_pkg::VEC_X87;
      next_event.saved_ip = x87_in.wait_ip;
      next_event.invalid_arith_operand = x87_unmasked[pfr_pkg::X87_IE] && !x87_in.status[pfr_pkg::X87_SF];
      next_event.x87_stack_fault = x87_unmasked[pfr_pkg::X87_IE] && x87_in.status[pfr_pkg::X87_SF];
    end
  end

  // event register toward dispatch
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fault_event <= '0;
    else
      fault_event <= next_event;
  end

  // fault address register; fault capture wins over a bus write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fault_address_register <= 64'h0000_0000_0000_0000;
    else if (next_event.valid && next_event.vector == pfr_pkg::VEC_PF)
      fault_address_register <= long_mode ? pf_in.lin_addr : {32'h0000_0000, pf_in.lin_addr[31:0]};
    else if (apb_wr && paddr == pfr_pkg::ADDR_FAULT_LO)
      fault_address_register <= long_mode ? {fault_address_register[63:32], pwdata}
        : {32'h0000_0000, pwdata};
    else if (apb_wr && paddr == pfr_pkg::ADDR_FAULT_HI && long_mode)
      fault_address_register <= {pwdata, fault_address_register[31:0]};
  end

  // last x87 instruction pointer with any exception flag set, masked or not
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      x87_last_ip <= 64'h0000_0000_0000_0000;
    else if (check_valid && x87_in.status[5:0] != 6'h00)
      x87_last_ip <= x87_in.last_fp_ip;
  end

  // control register; writes with must-be-zero bits are refused
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl <= pfr_pkg::CTRL_RESET;
    else if (apb_wr && paddr == pfr_pkg::ADDR_CTRL && !(|(pwdata & pfr_pkg::CTRL_MBZ)))
      ctrl <= pwdata;
  end

  // last delivered vector and code
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      last_err <= 32'h0000_0000;
      last_vec <= 8'h00;
    end
    else if (next_event.valid)
    begin
      last_err <= next_event.err_code;
      last_vec <= next_event.vector;
    end
  end

  // apb: zero wait, data registered in setup so it stands in access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !(paddr inside {pfr_pkg::ADDR_FAULT_LO, pfr_pkg::ADDR_FAULT_HI,
        pfr_pkg::ADDR_CTRL, pfr_pkg::ADDR_STATUS, pfr_pkg::ADDR_X87_IP_LO, pfr_pkg::ADDR_X87_IP_HI,
        pfr_pkg::ADDR_LAST_ERR});
      if (apb_rd)
        unique case (paddr)
          pfr_pkg::ADDR_FAULT_LO: prdata <= fault_address_register[31:0];
          pfr_pkg::ADDR_FAULT_HI: prdata <= fault_address_register[63:32];
          pfr_pkg::ADDR_CTRL: prdata <= ctrl;
          pfr_pkg::ADDR_STATUS: prdata <= {24'h00_0000, last_vec};
          pfr_pkg::ADDR_X87_IP_LO: prdata <= x87_last_ip[31:0];
          pfr_pkg::ADDR_X87_IP_HI: prdata <= x87_last_ip[63:32];
          pfr_pkg::ADDR_LAST_ERR: prdata <= last_err;
          default: prdata <= 32'h0000_0000;
        endcase
      else
        prdata <= prdata;
    end
  end

  // assertions
  property p_stack_vec;
    @(posedge pclk) disable iff (!presetn)
    (check_valid && stk_hit) |=> (fault_event.valid && fault_event.vector == 8'h0c);
  endproperty
  a_stack_vec: assert property (p_stack_vec) else $error("stack fault not on vector 12");

  property p_stack_err;
    @(posedge pclk) disable iff (!presetn)
    (check_valid && stack_in.stack_limit && !stack_in.ss_not_present) |=> fault_event.err_code == 32'h0000_0000;
  endproperty
  a_stack_err: assert property (p_stack_err) else $error("stack limit code not zero");

  property p_len;
    @(posedge pclk) disable iff (!presetn)
    (check_valid && !stk_hit && gp_in.instr_len > 5'd15 && !gp_sel_hit)
      |=> (fault_event.vector == 8'h0d && fault_event.err_code == 32'h0000_0000);
  endproperty
  a_len: assert property (p_len) else $error("long instruction not faulted");

  property p_priv;
    @(posedge pclk) disable iff (!presetn)
    (check_valid && !stk_hit && gp_in.priv_instr && gp_in.current_privilege_level != 2'b00) |=> fault_event.vector == 8'h0d;
  endproperty
  a_priv: assert property (p_priv) else $error("privileged instruction not faulted");

  property p_rsvd;
    @(posedge pclk) disable iff (!presetn)
    (check_valid && !stk_hit && !gp_sel_hit && !gp_zero_hit && pf_in.rsvd_bit && !pf_in.not_present
      && !pf_in.nx_fetch && !pf_in.prot_fail && !ctrl[pfr_pkg::CTRL_PSE] && !ctrl[pfr_pkg::CTRL_PAE])
      |=> fault_event.vector != 8'h0e;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit fault without enables");

  property p_cr2_legacy;
    @(posedge pclk) disable iff (!presetn)
    // a mode change alone keeps the upper half; a legacy page fault capture or low-half write clears it
    (!long_mode && ((next_event.valid && next_event.vector == pfr_pkg::VEC_PF)
      || (apb_wr && paddr == pfr_pkg::ADDR_FAULT_LO))) |=> fault_address_register[63:32] == 32'h0000_0000;
  endproperty
  a_cr2_legacy: assert property (p_cr2_legacy) else $error("upper address bits kept in legacy");

  property p_ne_off;
    @(posedge pclk) disable iff (!presetn)
    !ctrl[pfr_pkg::CTRL_NE] |=> fault_event.vector != 8'h10;
  endproperty
  a_ne_off: assert property (p_ne_off) else $error("x87 fault while enable clear");

  property p_x87_noerr;
    @(posedge pclk) disable iff (!presetn)
    (fault_event.valid && fault_event.vector == 8'h10) |-> !fault_event.err_valid;
  endproperty
  a_x87_noerr: assert property (p_x87_noerr) else $error("x87 fault with error code");

  property p_mask;
    @(posedge pclk) disable iff (!presetn)
    (check_valid && x87_in.wait_exec && (x87_in.status[5:0] & ~x87_in.mask) == 6'h00) |=> fault_event.vector != 8'h10;
  endproperty
  a_mask: assert property (p_mask) else $error("masked x87 flag reported");

  c_stack: cover property (@(posedge pclk) disable iff (!presetn) fault_event.vector == 8'h0c && fault_event.valid);
  c_gp_sel: cover property (@(posedge pclk) disable iff (!presetn) fault_event.vector == 8'h0d && fault_event.err_code != 0);
  c_pf: cover property (@(posedge pclk) disable iff (!presetn) fault_event.vector == 8'h0e && fault_event.valid);
  c_x87: cover property (@(posedge pclk) disable iff (!presetn) fault_event.x87_stack_fault);
endmodule // pfr_fault_unit

// *** shared/pfr_pkg.sv ***
// package for the protection fault reporting block
package pfr_pkg;
  localparam logic [7:0] VEC_STACK = 8'h0c;
  localparam logic [7:0] VEC_GP = 8'h0d;
  localparam logic [7:0] VEC_PF = 8'h0e;
  localparam logic [7:0] VEC_X87 = 8'h10;
  localparam logic [31:0] ERR_ZERO = 32'h0000_0000;
  localparam int MAX_INSTR_BYTES = 15;
  // apb register byte addresses
  localparam logic [7:0] ADDR_FAULT_LO = 8'h00;
  localparam logic [7:0] ADDR_FAULT_HI = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_X87_IP_LO = 8'h10;
  localparam logic [7:0] ADDR_X87_IP_HI = 8'h14;
  localparam logic [7:0] ADDR_LAST_ERR = 8'h18;
  // control register fields
  localparam int CTRL_NE = 0;
  localparam int CTRL_PSE = 1;
  localparam int CTRL_PAE = 2;
  localparam int CTRL_LONG = 3;
  localparam int CTRL_PE = 4;
  localparam int CTRL_CD = 5;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0020;
  localparam logic [31:0] CTRL_MBZ = 32'hffff_ffc0;
  // x87 status / control flag positions
  localparam int X87_IE = 0;
  localparam int X87_DE = 1;
  localparam int X87_ZE = 2;
  localparam int X87_OE = 3;
  localparam int X87_UE = 4;
  localparam int X87_PE = 5;
  localparam int X87_SF = 6;

  // stack fault causes from the pipeline
  typedef struct packed {
    logic noncanon_stack;
    logic ss_not_present;
    logic stack_limit;
    logic [15:0] ss_selector;
  } pfr_stack_t;

  // general protection causes
  typedef struct packed {
    logic null_sel_load;
    logic gate_null_sel;
    logic sys_desc_in_local;
    logic busy_task;
    logic is_iret;
    logic ext_type_nonzero;
    logic noncanon_base_off;
    logic gate_not_64;
    logic gate_16;
    logic task_transfer;
    logic [15:0] selector;
    logic [4:0] instr_len;
    logic priv_instr;
    logic [1:0] current_privilege_level;
    logic seg_limit;
    logic null_seg_access;
    logic ro_seg_write;
    logic sse_unaligned;
    logic code_limit;
    logic msr_ro;
    logic msr_noncanon;
    logic msr_bad_type;
  } pfr_gp_t;

  // page fault causes
  typedef struct packed {
    logic not_present;
    logic nx_fetch;
    logic prot_fail;
    logic rsvd_bit;
    logic [63:0] lin_addr;
    logic [31:0] pf_err;
  } pfr_pf_t;

  // x87 pending state
  typedef struct packed {
    logic wait_exec;
    logic [6:0] status;
    logic [5:0] mask;
    logic [63:0] wait_ip;
    logic [63:0] last_fp_ip;
  } pfr_x87_t;

  // event to handler dispatch
  typedef struct packed {
    logic valid;
    logic [7:0] vector;
    logic err_valid;
    logic [31:0] err_code;
    logic [63:0] saved_ip;
    logic x87_stack_fault;
    logic invalid_arith_operand;
  } pfr_event_t;
endpackage

// *** verif/pfr_fault_unit_test.sv ***
// self-checking bench for the protection fault unit
`timescale 1ns/1ps
module pfr_fault_unit_test;
  logic pclk, presetn, psel, penable, pwrite, go, cw, pready, pslverr, err, cv, p_cw;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, cwd, rd, ctl, p_cwd;
  logic [63:0] ip, p_ip, fa;
  logic [2:0] cr_req, cr;
  pfr_pkg::pfr_stack_t s, p_s;
  pfr_pkg::pfr_gp_t g, p_g;
  pfr_pkg::pfr_pf_t p, p_p;
  pfr_pkg::pfr_x87_t x, p_x;
  pfr_pkg::pfr_event_t ev, e;
  int mismatches, compares, events, n_exp, k, m;
  pfr_pipe_model pipe_u (.pclk(pclk), .presetn(presetn), .go(go), .ip(ip), .cr_req(cr_req), .cw(cw), .cwd(cwd),
    .s(s), .g(g), .p(p), .x(x), .check_valid(cv), .instr_ptr(p_ip), .cr_out(cr), .ctrl_write(p_cw),
    .ctrl_write_data(p_cwd), .stack_in(p_s), .gp_in(p_g), .pf_in(p_p), .x87_in(p_x), .fault_event(ev),
    .events(events));
  pfr_fault_unit dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .check_valid(cv),
    .instr_ptr(p_ip), .paging_enable_req(cr[2]), .not_write_through_req(cr[1]), .cache_disable_req(cr[0]),
    .ctrl_write_data(p_cwd), .ctrl_write(p_cw), .stack_in(p_s), .gp_in(p_g), .pf_in(p_p), .x87_in(p_x),
    .fault_event(ev));
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic conclude();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk_w(input string nm, input logic [63:0] ex, input logic [63:0] v);
    compares++;
    if (v !== ex)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, ex, v);
    end
  endtask
  // expected event from the stimulus held in the bench
  function automatic pfr_pkg::pfr_event_t model();
    pfr_pkg::pfr_event_t r;
    logic [5:0] pend;
    logic gs, gz, pf;
    r = '0;
    pend = x.status[5:0] & ~x.mask;
    gs = g.null_sel_load | g.gate_null_sel | g.sys_desc_in_local | (g.busy_task & !g.is_iret) | (ctl[3] &
      (g.ext_type_nonzero | g.noncanon_base_off | g.gate_not_64 | g.gate_16 | g.task_transfer));
    gz = (g.instr_len > pfr_pkg::MAX_INSTR_BYTES) | (g.priv_instr & (g.current_privilege_level != 2'h0)) | (|g[7:0]) |
      (cw & |(cwd & pfr_pkg::CTRL_MBZ)) | (cr_req[2] & !ctl[4]) | (cr_req[1] & !cr_req[0]);
    pf = p.not_present | p.nx_fetch | p.prot_fail | (p.rsvd_bit & (ctl[1] | ctl[2]));
    r.valid = 1'b1;
    r.err_valid = 1'b1;
    r.saved_ip = ip;
    if (s.noncanon_stack | s.ss_not_present | s.stack_limit)
    begin
      r.vector = pfr_pkg::VEC_STACK;
      r.err_code = s.ss_not_present ? {16'h0000, s.ss_selector & 16'hfff8} : pfr_pkg::ERR_ZERO;
    end
    else if (gs | gz)
    begin
      r.vector = pfr_pkg::VEC_GP;
      r.err_code = gs ? {16'h0000, g.selector & 16'hfff8} : pfr_pkg::ERR_ZERO;
    end
    else if (pf)
    begin
      r.vector = pfr_pkg::VEC_PF;
      r.err_code = p.pf_err;
    end
    else if (ctl[0] & x.wait_exec & (|pend))
    begin
      r.vector = pfr_pkg::VEC_X87;
      r.err_valid = 1'b0;
      r.saved_ip = x.wait_ip;
      r.invalid_arith_operand = pend[0] & !x.status[6];
      r.x87_stack_fault = pend[0] & x.status[6];
    end
    else
      r = '0;
    return r;
  endfunction
  task automatic chk_ev();
    pfr_pkg::pfr_event_t v;
    e = model();
    v = ev;
    if (!e.valid)
      v[$bits(v)-2:0] = e[$bits(e)-2:0];
    n_exp += int'(e.valid);
    chk_w("fault_event", 64'(e[$bits(e)-1:66]), 64'(v[$bits(v)-1:66]));
    chk_w("saved_ip", e.saved_ip, v.saved_ip);
    chk_w("x87_kind", 64'({e.x87_stack_fault, e.invalid_arith_operand}),
      64'({v.x87_stack_fault, v.invalid_arith_operand}));
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (n >= 20)
    begin
      mismatches++;
      conclude();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (w && a == pfr_pkg::ADDR_CTRL && !(|(d & pfr_pkg::CTRL_MBZ)))
      ctl = d;
    // idle edge so a following setup never reassigns psel in the same step
    @(posedge pclk);
  endtask
  task automatic clr();
    s <= {3'b000, 16'($urandom)};
    g <= '0;
    g.selector <= 16'($urandom);
    p <= {4'h0, $urandom, $urandom, $urandom};
    x <= '0;
    x.wait_ip <= {$urandom, $urandom};
    x.last_fp_ip <= {$urandom, $urandom};
    {cr_req, cw, cwd} <= '0;
    ip <= {$urandom, $urandom};
  endtask
  // the event answers one cycle after the sampling edge
  task automatic fire();
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    repeat (2) @(posedge pclk);
    chk_ev();
  endtask
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, go, paddr, pwdata} = '0;
    {mismatches, compares, n_exp} = '0;
    ctl = pfr_pkg::CTRL_RESET;
    void'($urandom(32'h0c87));
    clr();
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b1, pfr_pkg::ADDR_CTRL, 32'h8000_003f);
    apb(1'b0, pfr_pkg::ADDR_CTRL, 32'h0000_0000);
    chk_w("ctrl", pfr_pkg::CTRL_RESET, rd);
    chk_w("pslverr", 0, err);
    apb(1'b0, 8'h1c, 32'h0000_0000);
    chk_w("pslverr", 1, err);
    apb(1'b1, pfr_pkg::ADDR_FAULT_HI, 32'h1234_5678);
    apb(1'b0, pfr_pkg::ADDR_FAULT_HI, 32'h0000_0000);
    chk_w("fault_hi", 0, rd);
    for (k = 0; k < 3; k++)
    begin
      clr();
      s[18-k] <= 1'b1;
      fire();
    end
    for (m = 0; m < 2; m++)
    begin
      apb(1'b1, pfr_pkg::ADDR_CTRL, 32'h0000_0020 | 32'(m << 3));
      for (k = 0; k < 11; k++)
      begin
        clr();
        g[$bits(g)-1-((k == 10) ? 3 : (k % 10))] <= 1'b1;
        g.is_iret <= (k == 10);
        fire();
      end
    end
    for (k = 0; k < 8; k++)
    begin
      clr();
      g[7-k] <= 1'b1;
      fire();
      clr();
      g.instr_len <= 5'(13 + k);
      g.priv_instr <= k[2];
      g.current_privilege_level <= k[1:0];
      fire();
      clr();
      cw <= k[0];
      cwd <= 32'h0000_0040 << k;
      fire();
    end
    for (k = 0; k < 16; k++)
    begin
      if (k == 8)
        apb(1'b1, pfr_pkg::ADDR_CTRL, 32'h0000_0030);
      clr();
      cr_req <= k[2:0];
      fire();
    end
    fa = 0;
    for (m = 0; m < 4; m++)
    begin
      apb(1'b1, pfr_pkg::ADDR_CTRL, 32'h0000_0020 | 32'(m << 1) | ((m == 3) ? 32'h0000_0008 : 32'h0000_0000));
      for (k = 0; k < 4; k++)
      begin
        clr();
        p[99-k] <= 1'b1;
        fire();
        if (e.valid)
          fa = ctl[3] ? p.lin_addr : {32'h0000_0000, p.lin_addr[31:0]};
        apb(1'b0, pfr_pkg::ADDR_FAULT_LO, 32'h0000_0000);
        chk_w("fault_lo", fa[31:0], rd);
        apb(1'b0, pfr_pkg::ADDR_FAULT_HI, 32'h0000_0000);
        chk_w("fault_hi", fa[63:32], rd);
      end
    end
    apb(1'b1, pfr_pkg::ADDR_CTRL, 32'h0000_0021);
    for (k = 0; k < 21; k++)
    begin
      if (k == 18)
        apb(1'b1, pfr_pkg::ADDR_CTRL, 32'h0000_0020);
      clr();
      x.wait_exec <= (k != 19);
      x.status <= 7'(1 << (k % 7)) | ((k >= 14) ? 7'h01 : 7'h00);
      x.mask <= (k >= 7 && k < 14) ? 6'(1 << k - 7) : 6'h00;
      fire();
    end
    apb(1'b0, pfr_pkg::ADDR_X87_IP_LO, 32'h0000_0000);
    chk_w("x87_ip_lo", 64'(x.last_fp_ip[31:0]), 64'(rd));
    apb(1'b0, pfr_pkg::ADDR_X87_IP_HI, 32'h0000_0000);
    chk_w("x87_ip_hi", 64'(x.last_fp_ip[63:32]), 64'(rd));
    apb(1'b1, pfr_pkg::ADDR_CTRL, 32'h0000_0021);
    for (k = 0; k < 4; k++)
    begin
      clr();
      s.stack_limit <= (k < 1);
      g.seg_limit <= (k < 2);
      p.prot_fail <= (k < 3);
      x.wait_exec <= 1'b1;
      x.status <= 7'h01;
      fire();
    end
    apb(1'b0, pfr_pkg::ADDR_STATUS, 32'h0000_0000);
    chk_w("last_vec", 64'(e.vector), 64'(rd));
    apb(1'b0, pfr_pkg::ADDR_LAST_ERR, 32'h0000_0000);
    chk_w("last_err", 64'(e.err_code), 64'(rd));
    repeat (2) @(posedge pclk);
    chk_w("events", 64'(n_exp), 64'(events));
    conclude();
  end
endmodule // pfr_fault_unit_test

// *** verif/pfr_pipe_model.sv ***
// pipeline and dispatch stand-in for the fault unit
`timescale 1ns/1ps
module pfr_pipe_model
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench side
  input wire logic go,
  input wire logic [63:0] ip,
  input wire logic [2:0] cr_req,
  input wire logic cw,
  input wire logic [31:0] cwd,
  input wire pfr_pkg::pfr_stack_t s,
  input wire pfr_pkg::pfr_gp_t g,
  input wire pfr_pkg::pfr_pf_t p,
  input wire pfr_pkg::pfr_x87_t x,
  // fault unit side
  output logic check_valid,
  output logic [63:0] instr_ptr,
  output logic [2:0] cr_out,
  output logic ctrl_write,
  output logic [31:0] ctrl_write_data,
  output pfr_pkg::pfr_stack_t stack_in,
  output pfr_pkg::pfr_gp_t gp_in,
  output pfr_pkg::pfr_pf_t pf_in,
  output pfr_pkg::pfr_x87_t x87_in,
  // dispatch side
  input wire pfr_pkg::pfr_event_t fault_event,
  output int events
);
  // idle cycles flip the cause fields so an unqualified sample shows up
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {check_valid, instr_ptr, cr_out, ctrl_write, ctrl_write_data} <= '0;
      {stack_in, gp_in, pf_in, x87_in} <= '0;
      events <= 0;
    end
    else
    begin
      check_valid <= go;
      instr_ptr <= go ? ip : ~ip;
      cr_out <= go ? cr_req : 3'b000;
      ctrl_write <= go & cw;
      ctrl_write_data <= go ? cwd : ~cwd;
      stack_in <= go ? s : ~s;
      gp_in <= go ? g : ~g;
      pf_in <= go ? p : ~p;
      x87_in <= go ? x : ~x;
      events <= events + int'(fault_event.valid);
    end
  end
endmodule // pfr_pipe_model
